// *** include/incr_jump_consts.svh ***
`ifndef INCR_JUMP_CONSTS_SVH
`define INCR_JUMP_CONSTS_SVH

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define IJ_JUMP_TOP       3'h5
`define IJ_INCREMENT_FILE_REG_TOP       6'h0A
`define IJ_INCREMENT_SKIP_IF_ZERO_TOP     6'h0F
`define IJ_NOP_WORD       14'h0000
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IJ_IMM_MSB        10
`define IJ_DEST_BIT       7
`define IJ_FADDR_MSB      6
`define IJ_PAGE_MSB       4
`define IJ_PAGE_LSB       3
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IJ_PC_RESET       13'h0000
`define IJ_ACC_RESET      8'h00

`endif

// *** include/incr_jump_pkg.sv ***
package incr_jump_pkg;
    typedef enum logic [1:0] {
        OP_OTHER  = 2'b00,
        OP_JUMP   = 2'b01,
        OP_INCREMENT_FILE_REG   = 2'b10,
        OP_INCREMENT_SKIP_IF_ZERO = 2'b11
    } op_kind_t;

    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_FLUSH = 1'b1
    } exec_state_t;
endpackage : incr_jump_pkg

// *** src/incr_op_decode.sv ***
`timescale 1ns/100ps
`include "incr_jump_consts.svh"

module incr_op_decode (
    input  wire logic [13:0]               instr,
    output incr_jump_pkg::op_kind_t        kind
);
    always_comb begin
        if (instr[13:11] == `IJ_JUMP_TOP)
            kind = incr_jump_pkg::OP_JUMP;
        else if (instr[13:8] == `IJ_INCREMENT_FILE_REG_TOP)
            kind = incr_jump_pkg::OP_INCREMENT_FILE_REG;
        else if (instr[13:8] == `IJ_INCREMENT_SKIP_IF_ZERO_TOP)
            kind = incr_jump_pkg::OP_INCREMENT_SKIP_IF_ZERO;
        else
            kind = incr_jump_pkg::OP_OTHER;
    end
endmodule : incr_op_decode

// *** src/increment_and_jump_exec.sv ***
// Functional notes
// [RULE1] Jump opcode loads 11-bit immediate into pc
// [RULE2] Pc bits 12:11 come from page latch
// [RULE3] Jump always taken, two cycles, flags kept
// [RULE4] Skip-increment: add one, d selects destination
// [RULE5] Zero result flushes next instruction as no-op
// [RULE6] Plain increment updates zero flag, one cycle
// [RULE7] Seven-bit file address, d bit above
// [RULE8] Increment wraps modulo 256
`timescale 1ns/100ps
`include "incr_jump_consts.svh"

module increment_and_jump_exec (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr,
    input  wire logic [7:0]  pc_high_latch,
    input  wire logic [7:0]  file_rdata,
    output logic      [6:0]  file_addr,
    output logic      [12:0] program_counter,
    output logic             pc_load,
    output logic      [7:0]  acc,
    output logic             file_we,
    output logic      [7:0]  file_wdata,
    output logic             zero_we,
    output logic             zero_flag,
    output logic             flush,
    output logic      [13:0] exec_instr
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    incr_jump_pkg::op_kind_t     kind;
    incr_jump_pkg::exec_state_t  state_q, state_d;
    logic [13:0] eff_instr;
    logic [7:0]  sum;
    logic        is_inc, dest;

    // Fetched word is replaced by a no-op during the flush slot
    assign eff_instr = (state_q == incr_jump_pkg::ST_FLUSH)
                       ? `IJ_NOP_WORD : instr; // [RULE5]

    incr_op_decode u_dec (
        .instr (eff_instr),
        .kind  (kind)
    );

    assign is_inc = instr_valid &&
                    (kind == incr_jump_pkg::OP_INCREMENT_FILE_REG ||
                     kind == incr_jump_pkg::OP_INCREMENT_SKIP_IF_ZERO);
    assign dest   = eff_instr[`IJ_DEST_BIT]; // [RULE7]
    assign sum    = 8'(file_rdata + 8'h01); // [RULE8]

    // File address driven combinationally to the register file
    always_comb begin
        file_addr = eff_instr[`IJ_FADDR_MSB:0]; // [RULE7]
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [12:0] pc_d;
    logic        pc_load_d, file_we_d, zero_we_d, zero_d, flush_d;
    logic [7:0]  acc_d, wdata_d;
    logic [13:0] exec_d;

    always_comb begin
        state_d   = incr_jump_pkg::ST_RUN;
        pc_d      = program_counter;
        pc_load_d = 1'b0;
        acc_d     = acc;
        file_we_d = 1'b0;
        wdata_d   = file_wdata;
        zero_we_d = 1'b0;
        zero_d    = zero_flag;
        flush_d   = 1'b0;
        // Discarded slot always shows a no-op
        exec_d    = instr_valid ? eff_instr : `IJ_NOP_WORD; // [RULE5]
        case (state_q)
            incr_jump_pkg::ST_RUN: begin
                if (instr_valid && kind == incr_jump_pkg::OP_JUMP) begin
                    pc_d = {pc_high_latch[`IJ_PAGE_MSB:`IJ_PAGE_LSB],
                            eff_instr[`IJ_IMM_MSB:0]}; // [RULE1] [RULE2]
                    pc_load_d = 1'b1;
                    flush_d   = 1'b1;
                    state_d   = incr_jump_pkg::ST_FLUSH; // [RULE3]
                end
                if (is_inc) begin
                    if (dest) begin
                        file_we_d = 1'b1;
                        wdata_d   = sum; // [RULE4] [RULE6]
                    end else begin
                        acc_d = sum; // [RULE4] [RULE6]
                    end
                end
                if (is_inc && kind == incr_jump_pkg::OP_INCREMENT_FILE_REG) begin
                    zero_we_d = 1'b1;
                    zero_d    = (sum == 8'h00); // [RULE6]
                end
                if (is_inc && kind == incr_jump_pkg::OP_INCREMENT_SKIP_IF_ZERO &&
                    sum == 8'h00) begin
                    flush_d = 1'b1;
                    state_d = incr_jump_pkg::ST_FLUSH; // [RULE5]
                end
            end
            incr_jump_pkg::ST_FLUSH: begin
                state_d = incr_jump_pkg::ST_RUN;
            end
            default: begin
                state_d = incr_jump_pkg::ST_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q         <= incr_jump_pkg::ST_RUN;
            program_counter <= `IJ_PC_RESET;
            pc_load         <= 1'b0;
            acc             <= `IJ_ACC_RESET;
            file_we         <= 1'b0;
            file_wdata      <= 8'h00;
            zero_we         <= 1'b0;
            zero_flag       <= 1'b0;
            flush           <= 1'b0;
            exec_instr      <= `IJ_NOP_WORD;
        end else begin
            state_q         <= state_d;
            program_counter <= pc_d;
            pc_load         <= pc_load_d;
            acc             <= acc_d;
            file_we         <= file_we_d;
            file_wdata      <= wdata_d;
            zero_we         <= zero_we_d;
            zero_flag       <= zero_d;
            flush           <= flush_d;
            exec_instr      <= exec_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic accept;

    // Word taken for execution this cycle
    assign accept = instr_valid && (state_q == incr_jump_pkg::ST_RUN);

    // Raw opcode matches on the fetched word
    function automatic logic match_jump(input logic [13:0] w);
        return w[13:11] == `IJ_JUMP_TOP;
    endfunction : match_jump

    function automatic logic match_top6(input logic [13:0] w,
                                        input logic [5:0]  top);
        return w[13:8] == top;
    endfunction : match_top6

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_jump_pc_low: assert property ( // [RULE1]
        accept && match_jump(instr)
        |=> pc_load && program_counter[`IJ_IMM_MSB:0] ==
            $past(instr[`IJ_IMM_MSB:0]))
        else $error("jump immediate not loaded");
    a_jump_pc_page: assert property ( // [RULE2]
        accept && match_jump(instr)
        |=> program_counter[12:11] ==
            $past(pc_high_latch[`IJ_PAGE_MSB:`IJ_PAGE_LSB]))
        else $error("jump page bits wrong");
    a_jump_two_cyc: assert property ( // [RULE3]
        pc_load |-> flush && !zero_we ##1 !pc_load && !zero_we)
        else $error("jump not two cycles or flag touched");
    a_skip_no_flag: assert property ( // [RULE4]
        accept && match_top6(instr, `IJ_INCREMENT_SKIP_IF_ZERO_TOP) |=> !zero_we)
        else $error("skip increment changed zero flag");
    a_skip_flush: assert property ( // [RULE5]
        accept && match_top6(instr, `IJ_INCREMENT_SKIP_IF_ZERO_TOP) &&
        file_rdata == 8'hFF
        |=> flush ##1 exec_instr == `IJ_NOP_WORD)
        else $error("skip did not inject no-op");
    a_skip_miss: assert property ( // [RULE5]
        accept && match_top6(instr, `IJ_INCREMENT_SKIP_IF_ZERO_TOP) &&
        file_rdata != 8'hFF |=> !flush)
        else $error("skip taken on nonzero result");
    a_slot_idle: assert property ( // [RULE5]
        state_q == incr_jump_pkg::ST_FLUSH
        |=> !file_we && !zero_we && !pc_load && !flush &&
            exec_instr == `IJ_NOP_WORD)
        else $error("discarded word had an effect");
    a_inc_zero: assert property ( // [RULE6]
        accept && match_top6(instr, `IJ_INCREMENT_FILE_REG_TOP)
        |=> zero_we && !flush &&
            zero_flag == ($past(file_rdata) == 8'hFF))
        else $error("increment zero flag wrong");
    a_other_quiet: assert property ( // [RULE6]
        accept && !match_jump(instr) &&
        !match_top6(instr, `IJ_INCREMENT_FILE_REG_TOP) &&
        !match_top6(instr, `IJ_INCREMENT_SKIP_IF_ZERO_TOP)
        |=> !file_we && !zero_we && !pc_load && !flush)
        else $error("unhandled opcode had an effect");
    a_file_addr: assert property ( // [RULE7]
        state_q == incr_jump_pkg::ST_RUN
        |-> file_addr == instr[`IJ_FADDR_MSB:0])
        else $error("file address not from low bits");
    a_inc_dest: assert property ( // [RULE7]
        is_inc && instr[`IJ_DEST_BIT] |=> file_we &&
            file_wdata == 8'($past(file_rdata) + 8'h01))
        else $error("register destination not written");
    a_inc_acc: assert property ( // [RULE8]
        is_inc && !instr[`IJ_DEST_BIT] |=> !file_we &&
            acc == 8'($past(file_rdata) + 8'h01))
        else $error("accumulator increment wrong");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------

    c_jump:     cover property (pc_load);
    c_skip:     cover property (flush && !pc_load);
    c_inc_zero: cover property (zero_we && zero_flag);
    c_inc_acc:  cover property (is_inc && !instr[`IJ_DEST_BIT]);
    c_skip_miss: cover property (
        accept && match_top6(instr, `IJ_INCREMENT_SKIP_IF_ZERO_TOP) && file_rdata != 8'hFF);
endmodule : increment_and_jump_exec

// *** verif/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    logic        clk;
    logic        reset;
    logic        instr_valid;
    logic [13:0] instr;
    logic [7:0]  pc_high_latch;
    logic [7:0]  file_rdata;
    logic [6:0]  file_addr;
    logic [12:0] program_counter;
    logic        pc_load;
    logic [7:0]  acc;
    logic        file_we;
    logic [7:0]  file_wdata;
    logic        zero_we;
    logic        zero_flag;
    logic        flush;
    logic [13:0] exec_instr;
    int          err_count;
    int          n_tests;

    increment_and_jump_exec DUT (
        .clk(clk), .reset(reset), .instr_valid(instr_valid),
        .instr(instr), .pc_high_latch(pc_high_latch),
        .file_rdata(file_rdata), .file_addr(file_addr),
        .program_counter(program_counter), .pc_load(pc_load), .acc(acc),
        .file_we(file_we), .file_wdata(file_wdata), .zero_we(zero_we),
        .zero_flag(zero_flag), .flush(flush), .exec_instr(exec_instr)
    );

    always #2 clk = ~clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Present one word at the falling edge, settle after the rising edge
    task automatic step(input logic v, input logic [13:0] w,
                        input logic [7:0] rd);
        @(negedge clk);
        instr_valid = v;
        instr = w;
        file_rdata = rd;
        @(posedge clk);
        #1;
    endtask : step

    // Change the page latch with the core idle for one cycle
    task automatic set_page(input logic [7:0] pg);
        @(negedge clk);
        instr_valid = 1'b0;
        pc_high_latch = pg;
    endtask : set_page

    task automatic test_jump;
        set_page(8'hF5);
        step(1'b1, 14'h2FFF, 8'h00);
        chk(16'(program_counter), 16'h17FF);
        chk(16'(pc_load), 16'h0001);
        chk(16'(flush), 16'h0001);
        chk(16'(zero_we), 16'h0000);
        step(1'b1, 14'h0A80, 8'hFF);
        chk(16'(file_we), 16'h0000);
        chk(16'(exec_instr), 16'h0000);
        set_page(8'h08);
        step(1'b1, 14'h2800, 8'h00);
        chk(16'(program_counter), 16'h0800);
        step(1'b0, 14'h0000, 8'h00);
        $display("test_jump done");
    endtask : test_jump

    task automatic test_increment_file_reg;
        step(1'b1, 14'h0AFF, 8'hFF);
        chk(16'(file_addr), 16'h007F);
        chk(16'(file_we), 16'h0001);
        chk(16'(file_wdata), 16'h0000);
        chk(16'(zero_we), 16'h0001);
        chk(16'(zero_flag), 16'h0001);
        chk(16'(flush), 16'h0000);
        step(1'b1, 14'h0A05, 8'h41);
        chk(16'(acc), 16'h0042);
        chk(16'(file_we), 16'h0000);
        chk(16'(zero_flag), 16'h0000);
        $display("test_increment_file_reg done");
    endtask : test_increment_file_reg

    task automatic test_skip;
        step(1'b1, 14'h0F15, 8'h10);
        chk(16'(acc), 16'h0011);
        chk(16'(flush), 16'h0000);
        chk(16'(zero_we), 16'h0000);
        step(1'b1, 14'h0F95, 8'hFF);
        chk(16'(file_we), 16'h0001);
        chk(16'(file_wdata), 16'h0000);
        chk(16'(flush), 16'h0001);
        chk(16'(acc), 16'h0011);
        step(1'b1, 14'h0A85, 8'h00);
        chk(16'(file_we), 16'h0000);
        chk(16'(zero_we), 16'h0000);
        chk(16'(exec_instr), 16'h0000);
        step(1'b1, 14'h0A85, 8'h00);
        chk(16'(exec_instr), 16'h0A85);
        chk(16'(zero_flag), 16'h0000);
        $display("test_skip done");
    endtask : test_skip

    task automatic test_other;
        step(1'b1, 14'h0B05, 8'hFF);
        chk(16'(file_we), 16'h0000);
        chk(16'(zero_we), 16'h0000);
        chk(16'(flush), 16'h0000);
        chk(16'(acc), 16'h0011);
        step(1'b1, 14'h2000, 8'h00);
        chk(16'(pc_load), 16'h0000);
        step(1'b0, 14'h2FFF, 8'h00);
        chk(16'(pc_load), 16'h0000);
        chk(16'(program_counter), 16'h0800);
        $display("test_other done");
    endtask : test_other

    task automatic test_reset;
        set_page(8'h18);
        step(1'b1, 14'h2ABC, 8'h00);
        chk(16'(program_counter), 16'h1ABC);
        @(negedge clk);
        reset = 1'b1;
        instr_valid = 1'b0;
        @(posedge clk);
        #1;
        chk(16'(program_counter), 16'h0000);
        chk(16'(acc), 16'h0000);
        chk(16'(flush), 16'h0000);
        @(negedge clk);
        reset = 1'b0;
        step(1'b1, 14'h0A15, 8'h7F);
        chk(16'(acc), 16'h0080);
        step(1'b1, 14'h0A15, 8'hFF);
        chk(16'(acc), 16'h0000);
        chk(16'(zero_flag), 16'h0001);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        instr_valid = 1'b0;
        instr = 14'h0000;
        pc_high_latch = 8'h00;
        file_rdata = 8'h00;
        err_count = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        test_jump();
        test_increment_file_reg();
        test_skip();
        test_other();
        test_reset();
        test_done();
    end

    // Watchdog against a hang
    initial begin
        repeat (500) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule : testbench
